// file: rtl/burst_pkg.sv
package burst_pkg;
  // ==========================================================
  // sizes
  localparam int NUM_REGS = 25;
  localparam int BUF_BYTES = 37;
  localparam int MAX_ADDR_BYTES = 5;
  localparam int PRE_STEP_BITS = 4;
  localparam int DUMMY_READ_BITS = 2;
  localparam int CFG_BITS = 16;
  // ==========================================================
  // register offsets
  localparam logic [6:0] REG_MODE = 7'h00;
  localparam logic [6:0] REG_DATA_FN = 7'h02;
  localparam logic [6:0] REG_PKT = 7'h05;
  localparam logic [6:0] REG_PREAMBLE = 7'h06;
  localparam logic [6:0] REG_ADDR_LEN = 7'h08;
  localparam logic [6:0] REG_DEST_ADDR = 7'h09;
  localparam logic [6:0] REG_LOCAL_ADDR = 7'h0E;
  localparam logic [6:0] REG_IRQ = 7'h17;
  // ==========================================================
  // field positions
  localparam int TX_MODE_BIT = 7;
  localparam int BURST_BIT = 6;
  localparam int SCRAMBLE_BIT = 4;
  localparam int CRC_EN_BIT = 3;
  localparam int CRC_KEEP_BIT = 0;
  localparam int READOUT_N_BIT = 7;
  localparam int INSERT_N_BIT = 6;
  localparam int DEST_SEL_BIT = 5;
  localparam int FIFO_LEN_LSB = 0;
  localparam int PRE_LEN_LSB = 0;
  localparam int ADDR_LEN_LSB = 0;
  localparam int IRQ_POL_BIT = 0;
  localparam int SCR_TAP_HI = 6;
  localparam int SCR_TAP_LO = 3;
  // ==========================================================
  // reset values
  localparam logic [NUM_REGS*8-1:0] CFG_RESET = {168'h0, 8'h87, 8'h78, 8'h03, 8'h28};
  localparam logic [6:0] SCR_SEED = 7'h7f;
  localparam logic [15:0] CRC_INIT = 16'hffff;
  localparam logic [15:0] CRC_POLY = 16'h1021;
  // ==========================================================
  // link states
  typedef enum logic [2:0] {
    LS_IDLE = 3'b000,
    LS_PRE = 3'b001,
    LS_DEST = 3'b010,
    LS_SEND = 3'b011,
    LS_PAY = 3'b100,
    LS_CRC = 3'b101
  } link_state_t;
endpackage

// file: rtl/bit_coder.sv
`timescale 1ns/1ps
`default_nettype none
module bit_coder (
  // clock and reset
  input wire logic clk_in,
  input wire logic reset_in,
  // control
  input wire logic init_in,
  input wire logic step_in,
  input wire logic scramble_en_in,
  input wire logic descramble_in,
  input wire logic crc_feed_in,
  // data
  input wire logic bit_in,
  output logic coded_out,
  output logic [15:0] crc_out
);
  import burst_pkg::*;

  typedef struct packed {
    logic [6:0] scr;
    logic [15:0] crc;
  } coder_state_t;

  coder_state_t state_r;
  coder_state_t state_nxt;
  logic feedback;
  logic plain;

  // ==========================================================
  // additive scrambler and crc
  always_comb begin
    state_nxt = state_r;
    feedback = state_r.scr[SCR_TAP_HI] ^ state_r.scr[SCR_TAP_LO];
    coded_out = scramble_en_in ? (bit_in ^ feedback) : bit_in;
    plain = descramble_in ? coded_out : bit_in;
    if (init_in) begin
      state_nxt.scr = SCR_SEED;
      state_nxt.crc = CRC_INIT;
    end else if (step_in) begin
      if (scramble_en_in) begin
        state_nxt.scr = {state_r.scr[5:0], feedback};
      end
      if (crc_feed_in) begin
        state_nxt.crc = {state_r.crc[14:0], 1'b0} ^
                        ((plain ^ state_r.crc[15]) ? CRC_POLY : 16'h0000);
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      state_r <= '0;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign crc_out = state_r.crc;
endmodule
`default_nettype wire

// file: rtl/burst_packet_engine.sv
`timescale 1ns/1ps
`default_nettype none
module burst_packet_engine (
  // clock and reset
  input wire logic clk_in,
  input wire logic reset_in,
  // host serial port
  input wire logic sclk_in,
  input wire logic cs_in,
  input wire logic serial_data_line_in,
  output logic serial_data_line_out,
  output logic serial_data_line_oe_n_out,
  // mode and interrupt
  input wire logic mode_in,
  output logic irq_out,
  // modem transmit side
  input wire logic tx_bit_strobe_in,
  output logic tx_bit_out,
  output logic tx_active_out,
  // modem receive side
  input wire logic rx_frame_in,
  input wire logic rx_bit_in,
  input wire logic rx_bit_strobe_in
);
  import burst_pkg::*;

  typedef struct packed {
    logic [1:0] sclk_s;
    logic [1:0] cs_s;
    logic [1:0] sdi_s;
    logic [1:0] mode_s;
    logic sclk_d;
    logic mode_d;
    logic [NUM_REGS-1:0][7:0] cfg;
    logic [BUF_BYTES-1:0][7:0] buf_q;
    logic [4:0] sp_cnt;
    logic [7:0] sp_sh;
    logic [6:0] sp_addr;
    logic sp_wr;
    logic [8:0] host_bits;
    logic sdo;
    logic irq;
    logic rx_full;
    link_state_t ls;
    logic tx_dir;
    logic tx_act;
    logic tx_bit;
    logic [8:0] cnt;
    logic [15:0] sh;
    logic [5:0] wp;
    logic addr_ok;
    logic rx_seen;
  } engine_state_t;

  engine_state_t state_r;
  engine_state_t state_nxt;

  // ==========================================================
  // field decoders
  function automatic logic [2:0] addr_len(input logic [7:0] v);
    logic [2:0] f;
    f = v[ADDR_LEN_LSB +: 3];
    if (f == 3'h0) begin
      addr_len = 3'h1;
    end else if (f > 3'(MAX_ADDR_BYTES)) begin
      addr_len = 3'(MAX_ADDR_BYTES);
    end else begin
      addr_len = f;
    end
  endfunction

  function automatic logic [5:0] fifo_len(input logic [7:0] v);
    fifo_len = 6'({1'b0, v[FIFO_LEN_LSB +: 5]}) + 6'h01;
  endfunction

  function automatic logic [4:0] pre_bits(input logic [7:0] v);
    pre_bits = 5'((int'(v[PRE_LEN_LSB +: 2]) + 1) * PRE_STEP_BITS);
  endfunction

  // ==========================================================
  // shared helpers
  logic sclk_rise, sclk_fall, cs_hi, sdi, mode_edge, burst, txm;
  logic scramble_enable, crc_en, crc_keep, dest_sel, insert_n, readout_n;
  logic [2:0] alen;
  logic [5:0] flen, host_bytes, b;
  logic [8:0] fbits, idx;
  logic [7:0] rd_byte, byte_nxt;
  logic step, last, done, good, raw, coded, coder_init, scr_act;
  logic [15:0] crc_calc, rx_crc;

  bit_coder coder (
    .clk_in(clk_in),
    .reset_in(reset_in),
    .init_in(coder_init),
    .step_in(step),
    .scramble_en_in(scr_act),
    .descramble_in(~state_r.tx_dir),
    .crc_feed_in(state_r.ls == LS_PAY),
    .bit_in(state_r.tx_dir ? raw : rx_bit_in),
    .coded_out(coded),
    .crc_out(crc_calc)
  );

  always_comb begin
    state_nxt = state_r;
    state_nxt.sclk_s = {state_r.sclk_s[0], sclk_in};
    state_nxt.cs_s = {state_r.cs_s[0], cs_in};
    state_nxt.sdi_s = {state_r.sdi_s[0], serial_data_line_in};
    state_nxt.mode_s = {state_r.mode_s[0], mode_in};
    state_nxt.sclk_d = state_r.sclk_s[1];
    state_nxt.mode_d = state_r.mode_s[1];
    sclk_rise = state_r.sclk_s[1] & ~state_r.sclk_d;
    sclk_fall = ~state_r.sclk_s[1] & state_r.sclk_d;
    cs_hi = state_r.cs_s[1];
    sdi = state_r.sdi_s[1];
    mode_edge = state_r.mode_s[1] ^ state_r.mode_d;
    burst = state_r.cfg[REG_DATA_FN][BURST_BIT];
    txm = state_r.cfg[REG_MODE][TX_MODE_BIT];
    scramble_enable = burst & state_r.cfg[REG_DATA_FN][SCRAMBLE_BIT];
    crc_en = state_r.cfg[REG_DATA_FN][CRC_EN_BIT];
    crc_keep = state_r.cfg[REG_DATA_FN][CRC_KEEP_BIT];
    dest_sel = state_r.cfg[REG_PKT][DEST_SEL_BIT];
    insert_n = state_r.cfg[REG_PKT][INSERT_N_BIT];
    readout_n = state_r.cfg[REG_PKT][READOUT_N_BIT];
    alen = addr_len(state_r.cfg[REG_ADDR_LEN]);
    flen = fifo_len(state_r.cfg[REG_PKT]);
    if (txm) begin
      host_bytes = (dest_sel ? 6'(alen) : 6'h00) + flen;
    end else begin
      host_bytes = (readout_n ? 6'h00 : 6'(alen)) + flen;
    end
    rd_byte = (state_r.sp_addr < 7'(NUM_REGS)) ? state_r.cfg[state_r.sp_addr] : 8'h00;
    // data bit shown after the current fall
    idx = state_r.host_bits + 9'h001 - 9'(DUMMY_READ_BITS);
    coder_init = 1'b0;
    done = 1'b0;
    byte_nxt = 8'h00;

    // ==========================================================
    // configuration transfer, select high
    if (!cs_hi) begin
      state_nxt.sp_cnt = 5'h00;
    end else if (sclk_rise && state_r.sp_cnt != 5'(CFG_BITS)) begin
      state_nxt.sp_sh = {state_r.sp_sh[6:0], sdi};
      state_nxt.sp_cnt = state_r.sp_cnt + 5'h01;
      if (state_r.sp_cnt == 5'h07) begin
        state_nxt.sp_wr = state_nxt.sp_sh[7];
        state_nxt.sp_addr = state_nxt.sp_sh[6:0];
      end
      if (state_r.sp_cnt == 5'h0f && state_r.sp_wr && state_r.sp_addr < 7'(NUM_REGS)) begin
        state_nxt.cfg[state_r.sp_addr] = state_nxt.sp_sh;
      end
    end else if (sclk_fall && !state_r.sp_wr && state_r.sp_cnt[4:3] == 2'b01) begin
      state_nxt.sdo = rd_byte[~state_r.sp_cnt[2:0]];
    end

    // ==========================================================
    // fifo transfer, select low, burst only
    if (cs_hi || mode_edge) begin
      state_nxt.host_bits = 9'h000;
    end else if (burst && txm && sclk_rise && state_r.host_bits != 9'h1ff) begin
      state_nxt.sp_sh = {state_r.sp_sh[6:0], sdi};
      state_nxt.host_bits = state_r.host_bits + 9'h001;
      if (state_r.host_bits[2:0] == 3'h7 && state_r.host_bits[8:3] < host_bytes) begin
        state_nxt.buf_q[state_r.host_bits[8:3]] = state_nxt.sp_sh;
      end
    end else if (burst && !txm && sclk_fall && state_r.rx_full) begin
      state_nxt.host_bits = state_r.host_bits + 9'h001;
      if (state_r.host_bits < 9'(DUMMY_READ_BITS - 1)) begin
        state_nxt.sdo = 1'b0;
      end else if (idx == {host_bytes, 3'h0}) begin
        // last bit taken, trailing dummies see a released line
        state_nxt.sdo = 1'b0;
        state_nxt.rx_full = 1'b0;
      end else begin
        state_nxt.sdo = state_r.buf_q[idx[8:3]][~idx[2:0]];
        if (idx == {host_bytes - 6'h01, 3'h0}) begin
          state_nxt.irq = 1'b0;
        end
      end
    end else if (burst && !txm && state_r.host_bits == 9'h000) begin
      // first dummy stands before any falling edge
      state_nxt.sdo = 1'b0;
    end
    if (mode_edge) begin
      state_nxt.irq = 1'b0;
    end

    // ==========================================================
    // link framing
    b = state_r.cnt[8:3];
    step = (state_r.ls != LS_IDLE) &&
           (state_r.tx_dir ? tx_bit_strobe_in : rx_bit_strobe_in);
    scr_act = scramble_enable && state_r.ls != LS_IDLE && state_r.ls != LS_PRE;
    case (state_r.ls)
      LS_PRE: begin
        fbits = 9'(pre_bits(state_r.cfg[REG_PREAMBLE]));
        raw = ~state_r.cnt[0];
      end
      LS_DEST: begin
        fbits = 9'({alen, 3'h0});
        if (dest_sel) begin
          raw = state_r.buf_q[b][~state_r.cnt[2:0]];
        end else begin
          raw = state_r.cfg[int'(REG_DEST_ADDR) + int'(alen) - 1 - int'(b)][~state_r.cnt[2:0]];
        end
      end
      LS_SEND: begin
        fbits = 9'({alen, 3'h0});
        raw = state_r.cfg[int'(REG_LOCAL_ADDR) + int'(alen) - 1 - int'(b)][~state_r.cnt[2:0]];
      end
      LS_PAY: begin
        fbits = 9'({flen, 3'h0});
        raw = state_r.buf_q[(dest_sel ? 6'(alen) : 6'h00) + b][~state_r.cnt[2:0]];
      end
      LS_CRC: begin
        fbits = 9'h010;
        raw = crc_calc[~state_r.cnt[3:0]];
      end
      default: begin
        fbits = 9'h001;
        raw = 1'b0;
      end
    endcase
    last = state_r.cnt == fbits - 9'h001;
    rx_crc = {state_r.sh[14:0], coded};
    good = !crc_en || rx_crc == crc_calc;
    state_nxt.tx_bit = state_r.tx_act ? coded : 1'b0;

    if (state_r.ls == LS_IDLE && burst) begin
      if (txm && !state_r.mode_s[1] && state_r.mode_d) begin
        state_nxt.ls = LS_PRE;
        state_nxt.tx_dir = 1'b1;
        state_nxt.tx_act = 1'b1;
        state_nxt.cnt = 9'h000;
      end else if (!txm && state_r.mode_s[1] && !state_r.rx_full && rx_frame_in &&
                   !state_r.rx_seen) begin
        state_nxt.ls = LS_PRE;
        state_nxt.rx_seen = 1'b1;
        state_nxt.tx_dir = 1'b0;
        state_nxt.cnt = 9'h000;
        state_nxt.wp = 6'h00;
        state_nxt.addr_ok = 1'b1;
      end
    end else if (step) begin
      state_nxt.cnt = last ? 9'h000 : state_r.cnt + 9'h001;
      byte_nxt = {state_r.sh[6:0], coded};
      state_nxt.sh = {state_r.sh[14:0], coded};
      if (!state_r.tx_dir) begin
        if (state_r.ls == LS_DEST && coded !=
            state_r.cfg[int'(REG_LOCAL_ADDR) + int'(alen) - 1 - int'(b)][~state_r.cnt[2:0]]) begin
          state_nxt.addr_ok = 1'b0;
        end
        if (state_r.cnt[2:0] == 3'h7 && (state_r.ls == LS_PAY ||
            (state_r.ls == LS_SEND && !readout_n))) begin
          state_nxt.buf_q[state_r.wp] = byte_nxt;
          state_nxt.wp = state_r.wp + 6'h01;
        end
      end
      if (last) begin
        case (state_r.ls)
          LS_PRE: begin
            state_nxt.ls = LS_DEST;
            coder_init = 1'b1;
          end
          LS_DEST: begin
            if (!state_r.tx_dir && !state_nxt.addr_ok) begin
              state_nxt.ls = LS_IDLE;
            end else begin
              state_nxt.ls = insert_n ? LS_PAY : LS_SEND;
            end
          end
          LS_SEND: state_nxt.ls = LS_PAY;
          LS_PAY: begin
            state_nxt.ls = crc_en ? LS_CRC : LS_IDLE;
            done = !crc_en;
          end
          default: begin
            state_nxt.ls = LS_IDLE;
            done = 1'b1;
          end
        endcase
      end
    end

    // one reception per frame; a cut frame returns to idle
    if (!rx_frame_in) begin
      state_nxt.rx_seen = 1'b0;
      if (!state_nxt.tx_dir) begin
        state_nxt.ls = LS_IDLE;
      end
    end

    if (done) begin
      state_nxt.host_bits = 9'h000;
      if (state_r.tx_dir) begin
        state_nxt.irq = 1'b1;
        state_nxt.tx_act = 1'b0;
      end else if (good) begin
        state_nxt.rx_full = 1'b1;
        state_nxt.irq = 1'b1;
      end else if (crc_keep) begin
        state_nxt.rx_full = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      state_r <= '0;
      state_r.cfg <= CFG_RESET;
    end else begin
      state_r <= state_nxt;
    end
  end

  // ==========================================================
  // outputs
  assign serial_data_line_out = state_r.sdo;
  assign serial_data_line_oe_n_out = ~((state_r.cs_s[1] && !state_r.sp_wr &&
      state_r.sp_cnt[4:3] == 2'b01) || (!state_r.cs_s[1] && burst && !txm && state_r.rx_full));
  assign irq_out = state_r.cfg[REG_IRQ][IRQ_POL_BIT] ? state_r.irq : ~state_r.irq;
  assign tx_bit_out = state_r.tx_bit;
  assign tx_active_out = state_r.tx_act;
endmodule
`default_nettype wire

// file: verif/burst_packet_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module burst_packet_monitor (
  // clock and reset
  input wire logic clk_in,
  input wire logic reset_in,
  // host serial port
  input wire logic sclk_in,
  input wire logic cs_in,
  input wire logic serial_data_line_in,
  input wire logic serial_data_line_out,
  input wire logic serial_data_line_oe_n_out,
  // mode and interrupt
  input wire logic mode_in,
  input wire logic irq_out,
  // modem side
  input wire logic tx_bit_strobe_in,
  input wire logic tx_bit_out,
  input wire logic tx_active_out,
  input wire logic rx_frame_in,
  input wire logic rx_bit_in,
  input wire logic rx_bit_strobe_in
);
  typedef struct packed {
    logic [8:0] cnt;
  } mon_state_t;
  mon_state_t st_r;
  mon_state_t st_nxt;
  // ====================================
  // strobes taken in the current packet
  always_comb begin
    st_nxt = st_r;
    if (!tx_active_out) begin
      st_nxt.cnt = 9'h000;
    end else if (tx_bit_strobe_in) begin
      st_nxt.cnt = st_r.cnt + 9'h001;
    end
  end
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end
  default clocking @(posedge clk_in); endclocking
  default disable iff (reset_in);
  // ====================================
  // properties
  reset_idle_a: assert property (
    $past(reset_in) |-> irq_out && serial_data_line_oe_n_out && !tx_active_out)
    else $error("outputs not idle after reset");
  preamble_bits_a: assert property (
    tx_active_out && tx_bit_strobe_in && st_r.cnt < 9'h004 |-> tx_bit_out == ~st_r.cnt[0])
    else $error("preamble bit wrong");
  frame_len_a: assert property (
    $fell(tx_active_out) |-> st_r.cnt >= 9'h014 && st_r.cnt <= 9'h170)
    else $error("packet bit count out of range");
  tx_bit_hold_a: assert property (
    tx_active_out && $past(tx_active_out, 2) && !$past(tx_bit_strobe_in, 2)
    |-> $stable(tx_bit_out))
    else $error("tx bit moved without strobe");
  tx_start_a: assert property (
    $rose(tx_active_out) |-> !mode_in && $past(mode_in, 6))
    else $error("transmit began without mode fall");
  shift_fall_a: assert property (
    (sclk_in && !serial_data_line_oe_n_out) [*6] |-> $stable(serial_data_line_out))
    else $error("data moved while serial clock high");
  irq_quiet_a: assert property (
    ($stable(mode_in) && $stable(sclk_in) && !rx_bit_strobe_in && $stable(tx_active_out)) [*8]
    |-> $stable(irq_out))
    else $error("interrupt moved without cause");
  readout_dir_a: assert property (
    (!cs_in) [*4] ##0 !serial_data_line_oe_n_out |-> !tx_active_out)
    else $error("fifo readout during transmit");
  tx_done_c: cover property ($fell(tx_active_out));
  readout_c: cover property (!cs_in && !serial_data_line_oe_n_out);
  cfg_read_c: cover property (cs_in && !serial_data_line_oe_n_out);
  rx_irq_c: cover property (rx_frame_in && $changed(irq_out));
endmodule
bind burst_packet_engine burst_packet_monitor mon (
  .clk_in(clk_in), .reset_in(reset_in), .sclk_in(sclk_in), .cs_in(cs_in),
  .serial_data_line_in(serial_data_line_in), .serial_data_line_out(serial_data_line_out),
  .serial_data_line_oe_n_out(serial_data_line_oe_n_out), .mode_in(mode_in),
  .irq_out(irq_out), .tx_bit_strobe_in(tx_bit_strobe_in), .tx_bit_out(tx_bit_out),
  .tx_active_out(tx_active_out), .rx_frame_in(rx_frame_in), .rx_bit_in(rx_bit_in),
  .rx_bit_strobe_in(rx_bit_strobe_in)
);
`default_nettype wire

// file: verif/host_port_model.sv
`timescale 1ns/1ps
`default_nettype none
module host_port_model (
  // clock
  input wire logic clk_in,
  // device side of the data pin
  input wire logic dev_data_in,
  input wire logic dev_oe_n_in,
  // host pins
  output logic sclk_out,
  output logic cs_out,
  output logic line_out
);
  logic bit_r = 1'b0;
  logic drive_r = 1'b0;
  logic odd_r = 1'b0;
  // released line shows the inverse of the last host bit
  assign line_out = (dev_oe_n_in === 1'b0) ? dev_data_in : (bit_r ^ ~drive_r);
  initial begin
    sclk_out = 1'b0;
    cs_out = 1'b0;
  end
  // ====================================
  // one serial clock: data in low phase, sample at rise
  task automatic clock_bit(input logic b, input logic drv, output logic s);
    @(posedge clk_in);
    drive_r <= drv;
    if (drv) bit_r <= b;
    repeat (5) @(posedge clk_in);
    s = line_out;
    sclk_out <= 1'b1;
    repeat (6 + odd_r) @(posedge clk_in);
    sclk_out <= 1'b0;
    odd_r <= ~odd_r;
  endtask
  task automatic cfg_xfer(input logic wr, input logic [6:0] addr, input logic [7:0] wdata,
                          output logic [7:0] rdata);
    logic [15:0] word;
    logic s;
    word = {wr, addr, wdata};
    @(posedge clk_in);
    cs_out <= 1'b1;
    repeat (4) @(posedge clk_in);
    for (int i = 15; i >= 0; i--) begin
      clock_bit(word[i], wr || i > 7, s);
      if (i < 8) rdata[i] = s;
    end
    repeat (4) @(posedge clk_in);
    drive_r <= 1'b0;
    cs_out <= 1'b0;
    repeat (4) @(posedge clk_in);
  endtask
  task automatic fifo_write(input logic [15:0] data);
    logic s;
    for (int i = 18; i >= 0; i--) clock_bit(i > 2 ? data[i-3] : 1'b0, 1'b1, s);
    @(posedge clk_in);
    drive_r <= 1'b0;
  endtask
  task automatic fifo_read(output logic [20:0] q);
    logic s;
    for (int i = 20; i >= 0; i--) begin
      clock_bit(1'b0, 1'b0, s);
      q[i] = s;
    end
  endtask
endmodule
`default_nettype wire

// file: verif/burst_packet_engine_bench.sv
`timescale 1ns/1ps
`default_nettype none
module burst_packet_engine_bench;
  import burst_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic mode = 1'b0;
  logic tx_strobe = 1'b0;
  logic rx_frame = 1'b0;
  logic rx_bit = 1'b0;
  logic rx_strobe = 1'b0;
  logic sclk, cs, line, dev_data, dev_oe_n, irq, tx_bit, tx_active;
  logic pkt_q[$];
  logic [20:0] rq;
  int err_count = 0;
  int cmp_count = 0;
  always #5 clk = ~clk;
  burst_packet_engine dut (
    .clk_in(clk), .reset_in(rst), .sclk_in(sclk), .cs_in(cs),
    .serial_data_line_in(line), .serial_data_line_out(dev_data),
    .serial_data_line_oe_n_out(dev_oe_n), .mode_in(mode), .irq_out(irq),
    .tx_bit_strobe_in(tx_strobe), .tx_bit_out(tx_bit), .tx_active_out(tx_active),
    .rx_frame_in(rx_frame), .rx_bit_in(rx_bit), .rx_bit_strobe_in(rx_strobe)
  );
  host_port_model host (.clk_in(clk), .dev_data_in(dev_data), .dev_oe_n_in(dev_oe_n),
    .sclk_out(sclk), .cs_out(cs), .line_out(line));
  // ====================================
  // helpers
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("FAIL %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    logic [7:0] q;
    host.cfg_xfer(1'b1, a, d, q);
  endtask
  task automatic rd_chk(input logic [6:0] a, input logic [7:0] e);
    logic [7:0] q;
    host.cfg_xfer(1'b0, a, 8'h00, q);
    check(q, e);
  endtask
  task automatic make_pkt(input logic scr, input logic [15:0] adr, input logic [15:0] pay,
                          input logic bad);
    logic [47:0] body;
    logic [15:0] crc;
    logic [6:0] sr;
    logic fb;
    crc = CRC_INIT;
    for (int i = 15; i >= 0; i--) begin
      fb = crc[15] ^ pay[i];
      crc = {crc[14:0], 1'b0} ^ (fb ? CRC_POLY : 16'h0000);
    end
    body = {adr, pay, crc ^ {15'h0000, bad}};
    sr = SCR_SEED;
    pkt_q = '{1'b1, 1'b0, 1'b1, 1'b0};
    for (int i = 47; i >= 0; i--) begin
      fb = sr[SCR_TAP_HI] ^ sr[SCR_TAP_LO];
      pkt_q.push_back(body[i] ^ (scr & fb));
      sr = {sr[5:0], fb};
    end
  endtask
  task automatic send_chk(input logic scr);
    logic got_q[$];
    int n;
    wr(REG_DATA_FN, scr ? 8'h58 : 8'h48);
    make_pkt(scr, 16'h1234, 16'ha53c, 1'b0);
    @(posedge clk);
    mode <= 1'b1;
    repeat (8) @(posedge clk);
    host.fifo_write(16'ha53c);
    mode <= 1'b0;
    n = 0;
    while (!tx_active && n < 200) begin
      @(posedge clk);
      n++;
    end
    // first bit settles one clock after start
    @(posedge clk);
    while (tx_active && got_q.size() < 60) begin
      got_q.push_back(tx_bit);
      tx_strobe <= 1'b1;
      @(posedge clk);
      tx_strobe <= 1'b0;
      repeat (3) @(posedge clk);
    end
    check(got_q.size(), 52);
    foreach (got_q[i]) check(got_q[i], pkt_q[i]);
    check(irq, 1'b0);
  endtask
  task automatic rx_chk(input logic [15:0] adr, input logic bad, input logic exp);
    make_pkt(1'b1, adr, 16'ha53c, bad);
    @(posedge clk);
    rx_frame <= 1'b1;
    repeat (2) @(posedge clk);
    foreach (pkt_q[i]) begin
      rx_bit <= pkt_q[i];
      rx_strobe <= 1'b1;
      @(posedge clk);
      rx_strobe <= 1'b0;
      repeat (2) @(posedge clk);
    end
    rx_frame <= 1'b0;
    repeat (10) @(posedge clk);
    check(irq, exp);
  endtask
  task automatic read_chk();
    host.fifo_read(rq);
    check(rq[20:19], 2'b00);
    check(rq[18:3], 16'ha53c);
    check(irq, 1'b1);
  endtask
  task automatic complete_run();
    if (err_count == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // ====================================
  // sequence
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    for (int i = 0; i < 4; i++) rd_chk(7'(i), CFG_RESET[i*8 +: 8]);
    wr(7'h19, 8'hff);
    rd_chk(7'h19, 8'h00);
    wr(REG_PKT, 8'hc1);
    rd_chk(REG_PKT, 8'hc1);
    wr(REG_PREAMBLE, 8'h00);
    wr(REG_ADDR_LEN, 8'h02);
    wr(REG_DEST_ADDR, 8'h34);
    wr(REG_DEST_ADDR + 7'h01, 8'h12);
    wr(REG_LOCAL_ADDR, 8'h56);
    wr(REG_LOCAL_ADDR + 7'h01, 8'h78);
    wr(REG_MODE, 8'ha8);
    send_chk(1'b0);
    send_chk(1'b1);
    wr(REG_MODE, 8'h28);
    @(posedge clk);
    mode <= 1'b1;
    repeat (8) @(posedge clk);
    check(irq, 1'b1);
    rx_chk(16'h7857, 1'b0, 1'b1);
    rx_chk(16'h7856, 1'b1, 1'b1);
    rx_chk(16'h7856, 1'b0, 1'b0);
    read_chk();
    wr(REG_DATA_FN, 8'h59);
    rx_chk(16'h7856, 1'b1, 1'b1);
    read_chk();
    wr(REG_IRQ, 8'h01);
    check(irq, 1'b0);
    complete_run();
  end
  initial begin
    repeat (30000) @(posedge clk);
    err_count++;
    complete_run();
  end
endmodule
`default_nettype wire
